/* hw/audio_dsp_pkg.sv */
// audio_dsp_pkg: register map, field layout, reset values, timing and carriers of the audio dsp path
// assumes one 20 MHz clock and an AHB-Lite slave port; register index times four is the byte address
// Functional notes
// R1: writing a volume-update bit applies both pending left and right volumes together
// R2: record volume 00h mutes, 01h is -71.625dB, 0.375dB steps to EFh
// R3: playback volume 00h mutes, C0h is 0dB, codes above C0h stay at 0dB
// R4: ultrasonic mode outputs record data at four times rate, bypassing baseband filters
// R5: shared two-bit highpass cutoff code, separate left and right highpass enables
// R6: soft mute mutes when set, unmutes when clear, muted after reset
// R7: mute ramp advances every 2 samples, or every 32 with the rate bit set
// R8: unmute applies volumes at once, or ramps up to them when ramp select set
// R9: widening depth 00000 is off, effect active only while its enable is set
// R10: playback gate acts after selected hold time, three-bit threshold code passed on
// R11: detector compares rms threshold when mode bit is one, crest factor when zero
// R12: five-bit rms threshold and two-bit crest threshold codes reach the detector
// R13: range controller per-path enables; anti-clip and quick-release enabled from reset
// R14: attack rate code 0000 and 1100 to 1111 are reserved, reset 0100
// R15: decay rate codes 1001 to 1111 are reserved, reset 0010
// R16: attenuation limit code above 100 reserved, reset -12dB; boost limit resets 18dB
// R17: gated attenuation limit codes above 1100 reserved; expansion slope 1,2,4,8
// R18: quick-release threshold four codes; decay code 11 reserved
// R19: upper slope codes 110,111 reserved; lower slope codes above 100 reserved
// R20: knee input codes above 111100 reserved; knee output code 11111 reserved
// R21: second knee input applies with range gate on, output with its own enable
// R22: equalizer band gains are five-bit fields, reset 0_1100
// R23: volume-update bits read zero; stored volumes act only when the update is written
package audio_dsp_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int CYCLES_PER_MS = CLK_HZ / 1000;
  localparam int REG_COUNT = 14;

  localparam logic [11:0] IDX_REC_LEFT = 12'h400;
  localparam logic [11:0] IDX_REC_RIGHT = 12'h401;
  localparam logic [11:0] IDX_PLAY_LEFT = 12'h402;
  localparam logic [11:0] IDX_PLAY_RIGHT = 12'h403;
  localparam logic [11:0] IDX_REC_FILTERS = 12'h410;
  localparam logic [11:0] IDX_PLAY_MUTE = 12'h420;
  localparam logic [11:0] IDX_PLAY_WIDEN = 12'h421;
  localparam logic [11:0] IDX_PLAY_GATE = 12'h430;
  localparam logic [11:0] IDX_RC_ENABLES = 12'h440;
  localparam logic [11:0] IDX_RC_RATES = 12'h441;
  localparam logic [11:0] IDX_RC_SLOPES = 12'h442;
  localparam logic [11:0] IDX_RC_KNEE = 12'h443;
  localparam logic [11:0] IDX_RC_KNEE2 = 12'h444;
  localparam logic [11:0] IDX_EQ_GAINS = 12'h480;
  localparam logic [11:0] IDX_STATUS = 12'h4F0;
  localparam logic [11:0] IDX_ACTIVE = 12'h4F1;

  localparam logic [11:0] REG_INDEX [REG_COUNT] = '{IDX_REC_LEFT, IDX_REC_RIGHT, IDX_PLAY_LEFT, IDX_PLAY_RIGHT,
    IDX_REC_FILTERS, IDX_PLAY_MUTE, IDX_PLAY_WIDEN, IDX_PLAY_GATE, IDX_RC_ENABLES, IDX_RC_RATES,
    IDX_RC_SLOPES, IDX_RC_KNEE, IDX_RC_KNEE2, IDX_EQ_GAINS};
  localparam logic [15:0] REG_RESET [REG_COUNT] = '{16'h00C0, 16'h00C0, 16'h00C0, 16'h00C0, 16'h0000,
    16'h0200, 16'h0000, 16'h0068, 16'h0098, 16'h0845, 16'h0000, 16'h0000, 16'h0000, 16'h6318};
  localparam logic [15:0] REG_MASK [REG_COUNT] = '{16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF, 16'hF800,
    16'h02B0, 16'h3F00, 16'h006F, 16'hFFFF, 16'h1FFF, 16'hFFFF, 16'h07FF, 16'h03FF, 16'hFFFF};

  localparam logic [3:0] SLOT_REC_L = 4'h0;
  localparam logic [3:0] SLOT_REC_R = 4'h1;
  localparam logic [3:0] SLOT_PLAY_L = 4'h2;
  localparam logic [3:0] SLOT_PLAY_R = 4'h3;
  localparam logic [3:0] SLOT_REC_FILT = 4'h4;
  localparam logic [3:0] SLOT_MUTE = 4'h5;
  localparam logic [3:0] SLOT_WIDEN = 4'h6;
  localparam logic [3:0] SLOT_GATE = 4'h7;
  localparam logic [3:0] SLOT_RC1 = 4'h8;
  localparam logic [3:0] SLOT_RC2 = 4'h9;
  localparam logic [3:0] SLOT_RC3 = 4'hA;
  localparam logic [3:0] SLOT_RC4 = 4'hB;
  localparam logic [3:0] SLOT_RC5 = 4'hC;
  localparam logic [3:0] SLOT_EQ = 4'hD;

  localparam int VU_BIT = 8;
  localparam int ULTRA_BIT = 15;
  localparam int HPF_CUT_LSB = 13;
  localparam int HPF_L_BIT = 12;
  localparam int HPF_R_BIT = 11;
  localparam int MUTE_BIT = 9;
  localparam int MONO_BIT = 7;
  localparam int MUTE_RATE_BIT = 5;
  localparam int UNMUTE_RAMP_BIT = 4;
  localparam int WIDEN_DEPTH_LSB = 9;
  localparam int WIDEN_ON_BIT = 8;
  localparam int GATE_HOLD_LSB = 5;
  localparam int GATE_THR_LSB = 1;
  localparam int GATE_ON_BIT = 0;
  localparam int DET_RMS_LSB = 11;
  localparam int DET_PK_LSB = 9;
  localparam int RC_GATE_BIT = 8;
  localparam int DET_MODE_BIT = 7;
  localparam int DET_ON_BIT = 6;
  localparam int KNEE2_OUT_ON_BIT = 5;
  localparam int QR_ON_BIT = 4;
  localparam int ANTICLIP_BIT = 3;
  localparam int RC_PLAY_BIT = 2;
  localparam int RC_REC_L_BIT = 1;
  localparam int RC_REC_R_BIT = 0;
  localparam int ATTACK_LSB = 9;
  localparam int DECAY_LSB = 5;
  localparam int ATTEN_LSB = 2;
  localparam int BOOST_LSB = 0;
  localparam int GATED_ATTEN_LSB = 12;
  localparam int EXPANSION_LSB = 10;
  localparam int QR_THR_LSB = 8;
  localparam int QR_DECAY_LSB = 6;
  localparam int UPPER_SLOPE_LSB = 3;
  localparam int LOWER_SLOPE_LSB = 0;
  localparam int KNEE_IN_LSB = 5;
  localparam int KNEE_OUT_LSB = 0;
  localparam int EQ_BAND1_LSB = 11;
  localparam int EQ_BAND2_LSB = 6;
  localparam int EQ_BAND3_LSB = 1;
  localparam int EQ_ON_BIT = 0;

  localparam logic [7:0] REC_CODE_MAX = 8'hEF;
  localparam logic [7:0] PLAY_CODE_MAX = 8'hC0;
  localparam logic [5:0] FAST_RAMP_DIV = 6'h02;
  localparam logic [5:0] SLOW_RAMP_DIV = 6'h20;
  localparam int GATE_HOLD_MS_0 = 30;
  localparam int GATE_HOLD_MS_1 = 125;
  localparam int GATE_HOLD_MS_2 = 250;
  localparam int GATE_HOLD_MS_3 = 500;

  typedef struct packed {
    logic record_rate_x4;
    logic record_filter_bypass;
    logic [1:0] record_highpass_cutoff;
    logic record_left_highpass_on;
    logic record_right_highpass_on;
    logic playback_mono;
    logic [4:0] stereo_widening_depth;
    logic stereo_widening_active;
    logic [2:0] playback_gate_threshold;
    logic detector_on;
    logic detect_mode_select;
    logic [4:0] detect_threshold;
    logic range_gate_on;
    logic quick_release_on;
    logic anti_clip_on;
    logic range_ctrl_playback_on;
    logic range_ctrl_record_left_on;
    logic range_ctrl_record_right_on;
    logic [3:0] gain_attack_rate;
    logic [3:0] gain_decay_rate;
    logic [2:0] attenuation_limit;
    logic [1:0] boost_limit;
    logic [3:0] gated_attenuation_limit;
    logic [1:0] gate_expansion_slope;
    logic [1:0] quick_release_threshold;
    logic [1:0] quick_release_decay;
    logic [2:0] upper_compression_slope;
    logic [2:0] lower_compression_slope;
    logic [5:0] knee_input_level;
    logic [4:0] knee_output_level;
    logic second_knee_input_active;
    logic [4:0] second_knee_input_level;
    logic second_knee_output_active;
    logic [4:0] second_knee_output_level;
    logic [2:0][4:0] equalizer_band_gain;
    logic equalizer_on;
  } dsp_config_t;

  typedef struct packed {
    logic [7:0] record_left;
    logic [7:0] record_right;
    logic [7:0] playback_left;
    logic [7:0] playback_right;
    logic playback_gate_active;
    logic mute_ramping;
    logic range_ctrl_reserved;
  } dsp_gains_t;
endpackage : audio_dsp_pkg

/* hw/primary_port_audio_dsp_path.sv */
// primary_port_audio_dsp_path: control registers, volume update, soft mute ramp and noise gate hold
// assumes sample_tick and playback_quiet come from logic on clk; hready is this slave's own hreadyout
`timescale 1ns/1ns
module primary_port_audio_dsp_path #(
  parameter logic [23:0] GATE_HOLD_CYCLES_0 = 24'(audio_dsp_pkg::GATE_HOLD_MS_0 * audio_dsp_pkg::CYCLES_PER_MS),
  parameter logic [23:0] GATE_HOLD_CYCLES_1 = 24'(audio_dsp_pkg::GATE_HOLD_MS_1 * audio_dsp_pkg::CYCLES_PER_MS),
  parameter logic [23:0] GATE_HOLD_CYCLES_2 = 24'(audio_dsp_pkg::GATE_HOLD_MS_2 * audio_dsp_pkg::CYCLES_PER_MS),
  parameter logic [23:0] GATE_HOLD_CYCLES_3 = 24'(audio_dsp_pkg::GATE_HOLD_MS_3 * audio_dsp_pkg::CYCLES_PER_MS)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sample_tick,
  input wire logic playback_quiet,
  output audio_dsp_pkg::dsp_config_t cfg,
  output audio_dsp_pkg::dsp_gains_t gains
);
  import audio_dsp_pkg::*;

  typedef struct packed {
    logic [REG_COUNT-1:0][15:0] regs;
    logic [7:0] rec_act_l;
    logic [7:0] rec_act_r;
    logic [7:0] play_act_l;
    logic [7:0] play_act_r;
    logic [7:0] ramp_l;
    logic [7:0] ramp_r;
    logic ramp_up;
    logic mute_prev;
    logic [4:0] tick_cnt;
    logic [23:0] quiet_cnt;
    logic gate_active;
    logic reserved_code;
    dsp_config_t cfg;
    logic bus_wr;
    logic bus_rd;
    logic bus_low;
    logic [11:0] bus_index;
    logic [31:0] rdata;
  } state_t;

  function automatic state_t reset_state();
    state_t s;
    s = '0;
    for (int i = 0; i < REG_COUNT; i++) begin
      s.regs[i] = REG_RESET[i];
    end
    s.rec_act_l = REG_RESET[SLOT_REC_L][7:0];
    s.rec_act_r = REG_RESET[SLOT_REC_R][7:0];
    s.play_act_l = REG_RESET[SLOT_PLAY_L][7:0];
    s.play_act_r = REG_RESET[SLOT_PLAY_R][7:0];
    s.mute_prev = 1'b1;
    return s;
  endfunction : reset_state

  localparam state_t STATE_RESET = reset_state();

  function automatic logic [4:0] find_slot(input logic [11:0] idx);
    logic [4:0] hit;
    hit = 5'h00;
    for (int i = 0; i < REG_COUNT; i++) begin
      if (idx == REG_INDEX[i]) begin
        hit = {1'b1, 4'(i)};
      end
    end
    return hit;
  endfunction : find_slot

  function automatic logic [7:0] clamp_code(input logic [7:0] code, input logic [7:0] top);
    return (code > top) ? top : code;
  endfunction : clamp_code

  function automatic logic [7:0] step_toward(input logic [7:0] cur, input logic [7:0] tgt);
    logic [7:0] res;
    res = cur;
    if (cur < tgt) begin
      res = 8'(cur + 8'h01);
    end else if (cur > tgt) begin
      res = 8'(cur - 8'h01);
    end
    return res;
  endfunction : step_toward

  logic [1:0] rst_sync;
  logic rst_sync_n;
  state_t st;
  state_t next_st;
  logic [4:0] wslot;
  logic upd_rec;
  logic upd_play;
  logic ramp_step;
  logic [5:0] ramp_div;
  logic [23:0] hold_cycles;
  logic [7:0] tgt_l;
  logic [7:0] tgt_r;
  logic muted;
  logic [15:0] rf;
  logic [15:0] pm;
  logic [15:0] pw;
  logic [15:0] ng;
  logic [15:0] d1;
  logic [15:0] d2;
  logic [15:0] d3;
  logic [15:0] d4;
  logic [15:0] d5;
  logic [15:0] eq;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sync[1];

  assign rf = st.regs[SLOT_REC_FILT];
  assign pm = st.regs[SLOT_MUTE];
  assign pw = st.regs[SLOT_WIDEN];
  assign ng = st.regs[SLOT_GATE];
  assign d1 = st.regs[SLOT_RC1];
  assign d2 = st.regs[SLOT_RC2];
  assign d3 = st.regs[SLOT_RC3];
  assign d4 = st.regs[SLOT_RC4];
  assign d5 = st.regs[SLOT_RC5];
  assign eq = st.regs[SLOT_EQ];
  assign muted = pm[MUTE_BIT];
  assign tgt_l = st.play_act_l;
  assign tgt_r = st.play_act_r;
  assign wslot = find_slot(st.bus_index);
  assign ramp_div = pm[MUTE_RATE_BIT] ? SLOW_RAMP_DIV : FAST_RAMP_DIV;
  assign ramp_step = sample_tick && (st.tick_cnt >= 5'(ramp_div - 6'h01));

  always_comb begin
    case (ng[GATE_HOLD_LSB +: 2])
      2'b00: hold_cycles = GATE_HOLD_CYCLES_0;
      2'b01: hold_cycles = GATE_HOLD_CYCLES_1;
      2'b10: hold_cycles = GATE_HOLD_CYCLES_2;
      default: hold_cycles = GATE_HOLD_CYCLES_3;
    endcase
  end

  always_comb begin
    next_st = st;
    upd_rec = 1'b0;
    upd_play = 1'b0;
    next_st.bus_wr = 1'b0;
    next_st.bus_rd = 1'b0;
    // write data phase; update bits are never stored
    if (st.bus_wr && st.bus_low && wslot[4]) begin
      next_st.regs[wslot[3:0]] = hwdata[15:0] & REG_MASK[wslot[3:0]]; // R23
      upd_rec = hwdata[VU_BIT] && (wslot[3:0] == SLOT_REC_L || wslot[3:0] == SLOT_REC_R);
      upd_play = hwdata[VU_BIT] && (wslot[3:0] == SLOT_PLAY_L || wslot[3:0] == SLOT_PLAY_R);
    end
    if (upd_rec) begin
      next_st.rec_act_l = clamp_code(next_st.regs[SLOT_REC_L][7:0], REC_CODE_MAX); // R1 R2
      next_st.rec_act_r = clamp_code(next_st.regs[SLOT_REC_R][7:0], REC_CODE_MAX); // R1 R2
    end
    if (upd_play) begin
      next_st.play_act_l = clamp_code(next_st.regs[SLOT_PLAY_L][7:0], PLAY_CODE_MAX); // R1 R3
      next_st.play_act_r = clamp_code(next_st.regs[SLOT_PLAY_R][7:0], PLAY_CODE_MAX); // R1 R3
    end
    // read data phase, one wait state
    if (st.bus_rd) begin
      next_st.rdata = 32'h0000_0000;
      if (st.bus_low && wslot[4]) begin
        next_st.rdata = {16'h0000, st.regs[wslot[3:0]]};
      end else if (st.bus_low && st.bus_index == IDX_STATUS) begin
        next_st.rdata = {13'h0000, st.reserved_code, st.ramp_up, st.gate_active, st.ramp_r, st.ramp_l};
      end else if (st.bus_low && st.bus_index == IDX_ACTIVE) begin
        next_st.rdata = {st.play_act_r, st.play_act_l, st.rec_act_r, st.rec_act_l};
      end
    end
    // address phase
    if (hsel && hready && htrans[1]) begin
      next_st.bus_wr = hwrite;
      next_st.bus_rd = !hwrite;
      next_st.bus_low = (haddr[31:14] == 18'h0_0000);
      next_st.bus_index = haddr[13:2];
    end
    // soft mute ramp
    if (sample_tick) begin
      next_st.tick_cnt = ramp_step ? 5'h00 : 5'(st.tick_cnt + 5'h01); // R7
    end
    next_st.mute_prev = muted;
    if (muted) begin
      next_st.ramp_up = 1'b0;
      if (ramp_step) begin
        next_st.ramp_l = step_toward(st.ramp_l, 8'h00); // R6 R7
        next_st.ramp_r = step_toward(st.ramp_r, 8'h00); // R6 R7
      end
    end else if (st.mute_prev && pm[UNMUTE_RAMP_BIT]) begin
      next_st.ramp_up = 1'b1; // R8
    end else if (st.ramp_up) begin
      if (ramp_step) begin
        next_st.ramp_l = step_toward(st.ramp_l, tgt_l); // R7 R8
        next_st.ramp_r = step_toward(st.ramp_r, tgt_r); // R7 R8
      end
      if (st.ramp_l == tgt_l && st.ramp_r == tgt_r) begin
        next_st.ramp_up = 1'b0;
      end
    end else begin
      next_st.ramp_l = tgt_l; // R8
      next_st.ramp_r = tgt_r; // R8
    end
    // playback noise gate hold
    if (!ng[GATE_ON_BIT] || !playback_quiet) begin
      next_st.quiet_cnt = 24'h00_0000;
      next_st.gate_active = 1'b0;
    end else if (st.quiet_cnt >= hold_cycles) begin
      next_st.gate_active = 1'b1; // R10
    end else begin
      next_st.quiet_cnt = 24'(st.quiet_cnt + 24'h00_0001); // R10
    end
    // configuration seen by the datapath
    next_st.cfg.record_rate_x4 = rf[ULTRA_BIT]; // R4
    next_st.cfg.record_filter_bypass = rf[ULTRA_BIT]; // R4
    next_st.cfg.record_highpass_cutoff = rf[HPF_CUT_LSB +: 2]; // R5
    next_st.cfg.record_left_highpass_on = rf[HPF_L_BIT] && !rf[ULTRA_BIT]; // R4 R5
    next_st.cfg.record_right_highpass_on = rf[HPF_R_BIT] && !rf[ULTRA_BIT]; // R4 R5
    next_st.cfg.playback_mono = pm[MONO_BIT];
    next_st.cfg.stereo_widening_depth = pw[WIDEN_DEPTH_LSB +: 5]; // R9
    next_st.cfg.stereo_widening_active = pw[WIDEN_ON_BIT] && (pw[WIDEN_DEPTH_LSB +: 5] != 5'h00); // R9
    next_st.cfg.playback_gate_threshold = ng[GATE_THR_LSB +: 3]; // R10
    next_st.cfg.detector_on = d1[DET_ON_BIT]; // R11
    next_st.cfg.detect_mode_select = d1[DET_MODE_BIT]; // R11
    next_st.cfg.detect_threshold = d1[DET_MODE_BIT] ? d1[DET_RMS_LSB +: 5] : {3'b000, d1[DET_PK_LSB +: 2]}; // R11 R12
    next_st.cfg.range_gate_on = d1[RC_GATE_BIT];
    next_st.cfg.quick_release_on = d1[QR_ON_BIT]; // R13
    next_st.cfg.anti_clip_on = d1[ANTICLIP_BIT]; // R13
    next_st.cfg.range_ctrl_playback_on = d1[RC_PLAY_BIT]; // R13
    next_st.cfg.range_ctrl_record_left_on = d1[RC_REC_L_BIT]; // R13
    next_st.cfg.range_ctrl_record_right_on = d1[RC_REC_R_BIT]; // R13
    next_st.cfg.gain_attack_rate = d2[ATTACK_LSB +: 4]; // R14
    next_st.cfg.gain_decay_rate = d2[DECAY_LSB +: 4]; // R15
    next_st.cfg.attenuation_limit = d2[ATTEN_LSB +: 3]; // R16
    next_st.cfg.boost_limit = d2[BOOST_LSB +: 2]; // R16
    next_st.cfg.gated_attenuation_limit = d3[GATED_ATTEN_LSB +: 4]; // R17
    next_st.cfg.gate_expansion_slope = d3[EXPANSION_LSB +: 2]; // R17
    next_st.cfg.quick_release_threshold = d3[QR_THR_LSB +: 2]; // R18
    next_st.cfg.quick_release_decay = d3[QR_DECAY_LSB +: 2]; // R18
    next_st.cfg.upper_compression_slope = d3[UPPER_SLOPE_LSB +: 3]; // R19
    next_st.cfg.lower_compression_slope = d3[LOWER_SLOPE_LSB +: 3]; // R19
    next_st.cfg.knee_input_level = d4[KNEE_IN_LSB +: 6]; // R20
    next_st.cfg.knee_output_level = d4[KNEE_OUT_LSB +: 5]; // R20
    next_st.cfg.second_knee_input_active = d1[RC_GATE_BIT]; // R21
    next_st.cfg.second_knee_input_level = d5[KNEE_IN_LSB +: 5]; // R21
    next_st.cfg.second_knee_output_active = d1[KNEE2_OUT_ON_BIT]; // R21
    next_st.cfg.second_knee_output_level = d5[KNEE_OUT_LSB +: 5]; // R21
    next_st.cfg.equalizer_band_gain = {eq[EQ_BAND3_LSB +: 5], eq[EQ_BAND2_LSB +: 5], eq[EQ_BAND1_LSB +: 5]}; // R22
    next_st.cfg.equalizer_on = eq[EQ_ON_BIT];
    // flag any reserved range controller code
    next_st.reserved_code = (d2[ATTACK_LSB +: 4] == 4'h0) || (d2[ATTACK_LSB +: 4] >= 4'hC) // R14
      || (d2[DECAY_LSB +: 4] >= 4'h9) || (d2[ATTEN_LSB +: 3] >= 3'h5) // R15 R16
      || (d3[GATED_ATTEN_LSB +: 4] >= 4'hD) || (d3[QR_DECAY_LSB +: 2] == 2'h3) // R17 R18
      || (d3[UPPER_SLOPE_LSB +: 3] >= 3'h6) || (d3[LOWER_SLOPE_LSB +: 3] >= 3'h5) // R19
      || (d4[KNEE_IN_LSB +: 6] >= 6'h3D) || (d4[KNEE_OUT_LSB +: 5] == 5'h1F); // R20
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign hrdata = st.rdata;
  assign hreadyout = !st.bus_rd;
  assign hresp = 1'b0;
  assign cfg = st.cfg;
  assign gains = '{record_left: st.rec_act_l, record_right: st.rec_act_r, playback_left: st.ramp_l,
    playback_right: st.ramp_r, playback_gate_active: st.gate_active, mute_ramping: st.ramp_up,
    range_ctrl_reserved: st.reserved_code};

  volume_pair_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R1
    (upd_rec || upd_play) |=> (upd_rec ? (st.rec_act_l == clamp_code(st.regs[SLOT_REC_L][7:0], REC_CODE_MAX)
      && st.rec_act_r == clamp_code(st.regs[SLOT_REC_R][7:0], REC_CODE_MAX)) : 1'b1))
    else $error("record volumes not applied together");

  volume_hold_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R23
    !upd_rec && !upd_play |=> $stable(st.rec_act_l) && $stable(st.play_act_r))
    else $error("volume changed without update");

  volume_clamp_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R3
    st.play_act_l <= PLAY_CODE_MAX && st.rec_act_r <= REC_CODE_MAX && st.ramp_r <= PLAY_CODE_MAX)
    else $error("volume code above its top");

  mute_down_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R6
    muted && ramp_step && st.ramp_l != 8'h00 |=> st.ramp_l == 8'($past(st.ramp_l) - 8'h01))
    else $error("muted ramp did not step down");

  ramp_rate_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R7
    ramp_step |-> st.tick_cnt == 5'(ramp_div - 6'h01))
    else $error("ramp stepped at wrong sample count");

  unmute_now_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R8
    st.mute_prev && !muted && !pm[UNMUTE_RAMP_BIT] ##1 !muted |-> st.ramp_l == $past(tgt_l))
    else $error("unmute did not apply volume at once");

  ultrasonic_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R4
    rf[ULTRA_BIT] |=> cfg.record_filter_bypass && !cfg.record_left_highpass_on && !cfg.record_right_highpass_on)
    else $error("ultrasonic mode left filters on");

  gate_hold_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R10
    $rose(st.gate_active) |-> $past(st.quiet_cnt) >= $past(hold_cycles) && $past(ng[GATE_ON_BIT]))
    else $error("gate active before hold time");

  widening_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R9
    cfg.stereo_widening_active |-> cfg.stereo_widening_depth != 5'h00 && $past(pw[WIDEN_ON_BIT]))
    else $error("widening active while off");

  read_wait_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // read data answered after one wait state
    hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read answer not after one wait state");

  attack_code_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R14
    d2[ATTACK_LSB +: 4] == 4'h0 |=> st.reserved_code)
    else $error("reserved attack code not flagged");

  play_pair_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R1
    upd_play |=> st.play_act_l == clamp_code(st.regs[SLOT_PLAY_L][7:0], PLAY_CODE_MAX)
      && st.play_act_r == clamp_code(st.regs[SLOT_PLAY_R][7:0], PLAY_CODE_MAX))
    else $error("playback volumes not applied together");

  highpass_on_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R5
    !rf[ULTRA_BIT] |=> cfg.record_left_highpass_on == $past(rf[HPF_L_BIT])
      && cfg.record_right_highpass_on == $past(rf[HPF_R_BIT]))
    else $error("highpass enable not followed");

  gate_drop_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R10
    !playback_quiet || !ng[GATE_ON_BIT] |=> !st.gate_active)
    else $error("gate stayed active without quiet input");
endmodule : primary_port_audio_dsp_path

/* tb/audio_source_model.sv */
// audio_source_model: far-side sample tick and quiet level
// assumes the dsp clock; one tick every four cycles while tick_on
`timescale 1ns/1ns
module audio_source_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick_on,
  input wire logic quiet_on,
  output logic sample_tick,
  output logic playback_quiet
);
  logic [1:0] div;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div <= 2'h0;
      sample_tick <= 1'b0;
      playback_quiet <= 1'b0;
    end else begin
      div <= div + 2'h1;
      sample_tick <= tick_on && (div == 2'h3);
      playback_quiet <= quiet_on;
    end
  end
endmodule : audio_source_model

/* tb/primary_port_audio_dsp_path_tb_top.sv */
// primary_port_audio_dsp_path_tb_top: register, volume, mute and gate checks
// assumes one AHB-Lite master here and the source model on the far side
`timescale 1ns/1ns
module primary_port_audio_dsp_path_tb_top;
  import audio_dsp_pkg::*;
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, tick_on = 0, quiet_on = 0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic hreadyout, hresp, sample_tick, playback_quiet;
  dsp_config_t cfg;
  dsp_gains_t gains;
  int fails = 0, samples_checked = 0, cycles = 0;
  initial forever #25 clk = ~clk;
  audio_source_model i_src (.clk(clk), .rst_n(rst_n), .tick_on(tick_on), .quiet_on(quiet_on),
    .sample_tick(sample_tick), .playback_quiet(playback_quiet));
  primary_port_audio_dsp_path #(.GATE_HOLD_CYCLES_0(24'h0014), .GATE_HOLD_CYCLES_1(24'h0028),
    .GATE_HOLD_CYCLES_2(24'h003C), .GATE_HOLD_CYCLES_3(24'h0050)) i_dut (.clk(clk), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .sample_tick(sample_tick), .playback_quiet(playback_quiet), .cfg(cfg), .gains(gains));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic wait_rdy(output logic [31:0] q);
    logic r;
    do begin
      @(negedge clk);
      r = hreadyout;
      q = hrdata;
      @(posedge clk);
    end while (r !== 1'b1);
  endtask : wait_rdy
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    wait_rdy(q);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy(q);
  endtask : xfer
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, rd);
  endtask : wr
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000, rd);
    chk(rd, exp);
  endtask : rdc
  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask : gap
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < REG_COUNT; i++) begin
      rdc(32'({REG_INDEX[i], 2'b00}), 32'(REG_RESET[i]));
    end
    chk(32'({cfg.detect_mode_select, cfg.quick_release_on, cfg.anti_clip_on, cfg.range_ctrl_playback_on}),
      32'h0000_000E);
    rdc(32'h0000_1010, 32'h0000_0000);
    wr(32'h0000_1000, 32'h0000_0012);
    rdc(32'h0000_13C4, 32'hC0C0_C0C0);
    rdc(32'h0000_1000, 32'h0000_0012);
    wr(32'h0000_1004, 32'h0000_0134);
    rdc(32'h0000_1004, 32'h0000_0034);
    rdc(32'h0000_13C4, 32'hC0C0_3412);
    wr(32'h0000_1000, 32'h0000_01FF);
    rdc(32'h0000_13C4, 32'hC0C0_34EF);
    chk(32'({gains.record_left, gains.record_right}), 32'h0000_EF34);
    wr(32'h0000_1008, 32'h0000_01A0);
    wr(32'h0000_100C, 32'h0000_01FF);
    rdc(32'h0000_13C4, 32'hC0A0_34EF);
    rdc(32'h0000_13C0, 32'h0000_0000);
    wr(32'h0000_1080, 32'h0000_0000);
    gap(4);
    chk({gains.playback_left, gains.playback_right}, 32'h0000_A0C0);
    tick_on <= 1'b1;
    wr(32'h0000_1080, 32'h0000_0200);
    gap(40);
    chk(32'(gains.playback_left > 8'h99 && gains.playback_left < 8'h9E), 32'h0000_0001);
    wr(32'h0000_1080, 32'h0000_0010);
    gap(4);
    chk(32'(gains.mute_ramping), 32'h0000_0001);
    gap(150);
    chk({gains.mute_ramping, gains.playback_left, gains.playback_right}, 32'h0000_A0C0);
    wr(32'h0000_10C0, 32'h0000_0001);
    quiet_on <= 1'b1;
    gap(10);
    chk(32'(gains.playback_gate_active), 32'h0000_0000);
    gap(30);
    chk(32'(gains.playback_gate_active), 32'h0000_0001);
    quiet_on <= 1'b0;
    gap(4);
    chk(32'(gains.playback_gate_active), 32'h0000_0000);
    wr(32'h0000_1040, 32'h0000_FFFF);
    rdc(32'h0000_1040, 32'h0000_F800);
    chk(32'({cfg.record_rate_x4, cfg.record_filter_bypass, cfg.record_left_highpass_on,
      cfg.record_right_highpass_on, cfg.record_highpass_cutoff}), 32'h0000_0033);
    wr(32'h0000_1084, 32'h0000_0300);
    gap(4);
    chk(32'({cfg.stereo_widening_active, cfg.stereo_widening_depth}), 32'h0000_0021);
    wr(32'h0000_1084, 32'h0000_0200);
    gap(4);
    chk(32'({cfg.stereo_widening_active, cfg.stereo_widening_depth}), 32'h0000_0001);
    wr(32'h0000_1104, 32'h0000_0000);
    gap(4);
    chk(32'({hresp, gains.range_ctrl_reserved}), 32'h0000_0001);
    wr(32'h0000_1080, 32'h0000_0220);
    gap(300);
    chk(32'(gains.playback_left > 8'h9C && gains.playback_left < 8'h9F), 32'h0000_0001);
    wrap_up();
  end
endmodule : primary_port_audio_dsp_path_tb_top
